// ==== logic/hrc_pkg.sv ====
package hrc_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_IFIELD = 8'h04;
  localparam logic [7:0] OFF_SHBURST = 8'h08;
  localparam logic [7:0] OFF_CMD = 8'h0C;
  localparam logic [7:0] OFF_TXLEN = 8'h10;
  localparam logic [7:0] OFF_TXDATA = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_RXOFFSET = 8'h1C;
  localparam logic [7:0] OFF_RXIFIELD = 8'h20;
  localparam logic [7:0] OFF_RXDATA = 8'h24;
  // control field positions
  localparam int CTRL_TX_EN = 0;
  localparam int CTRL_LONG_TERM = 1;
  localparam int CTRL_MULTI_WRITE = 2;
  localparam int CTRL_RX_ACCEPT = 3;
  localparam int CTRL_W = 4;
  // command field positions (write-only pulses)
  localparam int CMD_END_PKT = 0;
  localparam int CMD_DISCONNECT = 1;
  // reset values
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam logic [31:0] IFIELD_RESET = 32'h0000_0000;
  localparam logic [7:0] SHBURST_RESET = 8'h00;
  // burst and transfer sizes
  localparam logic [8:0] STD_BURST_WORDS = 9'h100;
  localparam int XFER_WORDS_W = 23;
  localparam int BYTES_PER_WORD = 4;
  // receive queue
  localparam int RXQ_DEPTH = 8;
  localparam int RXQ_AW = 3;
  localparam logic [3:0] RXQ_READY_LIMIT = 4'h4;
  localparam int RX_SYNC_W = 67;

  typedef enum logic [2:0] {
    TX_IDLE,
    TX_CONNECT,
    TX_OPEN,
    TX_PACKET,
    TX_DROP
  } hrc_tx_state_t;
endpackage : hrc_pkg

// ==== logic/hrc_raw_access.sv ====
`timescale 1ns/10ps
// Contract
// - accept every arriving packet; no rejection or protocol-id filtering
// - queue each received packet whole; headers pass as plain payload
// - keep readable running byte offset within current received packet
// - single-packet mode: connect before each packet, disconnect after it
// - long-term mode: connection held across packets until host asks disconnect
// - multi-write packet keeps PACKET asserted across several host writes
// - single-write packet drops PACKET once that write's data is sent
// - packet may stay open across writes indefinitely until host ends it
// - configured short first burst sent first, from start of first write
// - host may end a multi-write packet before its bytecount is sent
// - transmit only host data bytes; no header or framing added
// - only I-field and short-burst setting used from transmit settings
// - present configured I-field at each connection setup, unaltered
// - pass received I-field through unaltered
// - accept every incoming connection once receive accept enabled
// - deliver received words strictly in arrival order
// - short first burst 1 to 255 words; standard burst 256 words
module hrc_raw_access (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic txRequest,
  output logic [31:0] txIfield,
  output logic txPacket,
  output logic txBurst,
  output logic txWordValid,
  output logic [31:0] txData,
  input wire logic txConnectAck,
  input wire logic txRemoteReady,
  input wire logic rxRequest,
  input wire logic [31:0] rxIfield,
  input wire logic rxPacket,
  input wire logic rxWordValid,
  input wire logic [31:0] rxData,
  output logic rxConnect,
  output logic rxReady
);
  hrc_pkg::hrc_tx_state_t txState_r;
  logic [hrc_pkg::CTRL_W-1:0] ctrl_r;
  logic [31:0] ifield_r;
  logic [7:0] shBurst_r;
  logic [hrc_pkg::XFER_WORDS_W-1:0] wordsLeft_r;
  logic [8:0] burstLeft_r;
  logic [31:0] rxOffset_r;
  logic [31:0] rxIfieldHold_r;
  logic rxPacketPrev_r;
  logic [31:0] rxqData_r [hrc_pkg::RXQ_DEPTH];
  logic rxqFirst_r [hrc_pkg::RXQ_DEPTH];
  logic [hrc_pkg::RXQ_AW-1:0] rxqWr_r;
  logic [hrc_pkg::RXQ_AW-1:0] rxqRd_r;
  logic [3:0] rxqCount_r;
  logic [1:0] txSyncQ;
  logic [hrc_pkg::RX_SYNC_W-1:0] rxSyncQ;

  // every link input crosses two flops before use
  hrc_sync #(.W(2)) txSync (
    .sys_clk(sys_clk),
    .srst(srst),
    .d({txConnectAck, txRemoteReady}),
    .q(txSyncQ)
  );
  hrc_sync #(.W(hrc_pkg::RX_SYNC_W)) rxSync (
    .sys_clk(sys_clk),
    .srst(srst),
    .d({rxRequest, rxIfield, rxPacket, rxWordValid, rxData}),
    .q(rxSyncQ)
  );

  // synchronised link inputs split back into their fields
  wire ackS = txSyncQ[1];
  wire remoteReadyS = txSyncQ[0];
  wire rxReqS = rxSyncQ[66];
  wire [31:0] rxIfieldS = rxSyncQ[65:34];
  wire rxPacketS = rxSyncQ[33];
  wire rxValidS = rxSyncQ[32];
  wire [31:0] rxDataS = rxSyncQ[31:0];

  // apb decode
  wire accessReq = psel & penable & ~pready;
  wire commit = psel & penable & pready;
  wire selCtrl = (paddr == hrc_pkg::OFF_CTRL);
  wire selIfield = (paddr == hrc_pkg::OFF_IFIELD);
  wire selShBurst = (paddr == hrc_pkg::OFF_SHBURST);
  wire selCmd = (paddr == hrc_pkg::OFF_CMD);
  wire selTxLen = (paddr == hrc_pkg::OFF_TXLEN);
  wire selTxData = (paddr == hrc_pkg::OFF_TXDATA);
  wire selStatus = (paddr == hrc_pkg::OFF_STATUS);
  wire selRxOffset = (paddr == hrc_pkg::OFF_RXOFFSET);
  wire selRxIfield = (paddr == hrc_pkg::OFF_RXIFIELD);
  wire selRxData = (paddr == hrc_pkg::OFF_RXDATA);
  wire mapped = selCtrl | selIfield | selShBurst | selCmd | selTxLen | selTxData
    | selStatus | selRxOffset | selRxIfield | selRxData;
  wire writeOnly = selCmd | selTxLen | selTxData;
  wire readOnly = selStatus | selRxOffset | selRxIfield | selRxData;
  wire badAccess = ~mapped | (pwrite & readOnly) | (~pwrite & writeOnly);

  // tx transfer readiness; a word waits in the access phase until the link can take it
  wire inPacket = (txState_r == hrc_pkg::TX_PACKET);
  wire lenAccept = (wordsLeft_r == '0) && ((txState_r == hrc_pkg::TX_IDLE)
    || (txState_r == hrc_pkg::TX_OPEN) || inPacket);
  wire dataAccept = inPacket && (wordsLeft_r != '0) && remoteReadyS;
  wire rxqEmpty = (rxqCount_r == 4'h0);
  wire canFinish = badAccess
    | ~((selTxLen & pwrite & ~lenAccept) | (selTxData & pwrite & ~dataAccept)
    | (selRxData & ~pwrite & rxqEmpty));
  wire doWrite = commit & pwrite & ~badAccess;
  wire doRead = commit & ~pwrite & ~badAccess;

  // actions that take effect at the committing edge
  wire lenWrite = doWrite & selTxLen;
  // a length ignored while off and idle must not arm the counter, or the next one stalls
  wire lenLoad = lenWrite & (ctrl_r[hrc_pkg::CTRL_TX_EN] | (txState_r != hrc_pkg::TX_IDLE));
  wire wordSend = doWrite & selTxData;
  wire cmdEnd = doWrite & selCmd & pwdata[hrc_pkg::CMD_END_PKT];
  wire cmdDisc = doWrite & selCmd & pwdata[hrc_pkg::CMD_DISCONNECT];
  wire rxPop = doRead & selRxData;
  wire multiWrite = ctrl_r[hrc_pkg::CTRL_MULTI_WRITE];
  wire [hrc_pkg::XFER_WORDS_W-1:0] lenWords = pwdata[24:2]; // bytes to words
  // single-write packet finishes with the last word of its write
  wire singleDone = wordSend & ~multiWrite & (wordsLeft_r == hrc_pkg::XFER_WORDS_W'(1));
  wire packetEnd = singleDone | (inPacket & multiWrite & cmdEnd);
  // first burst takes the short count if one is set
  wire [8:0] firstBurst = (shBurst_r != 8'h00) ? {1'b0, shBurst_r} : hrc_pkg::STD_BURST_WORDS;

  // read mux
  wire [31:0] statusWord = {16'h0000, rxqCount_r, 3'h0, ~rxqEmpty & rxqFirst_r[rxqRd_r],
    rxConnect, txPacket, txRequest, ackS, 1'b0, txState_r};
  wire [31:0] rdMux = selCtrl ? {28'h0000000, ctrl_r}
    : selIfield ? ifield_r
    : selShBurst ? {24'h000000, shBurst_r}
    : selStatus ? statusWord
    : selRxOffset ? rxOffset_r
    : selRxIfield ? rxIfieldHold_r
    : selRxData ? rxqData_r[rxqRd_r]
    : 32'h0000_0000;

  // apb answer: pready one cycle after the request can finish
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= accessReq & canFinish;
      pslverr <= accessReq & canFinish & badAccess;
      prdata <= (accessReq & canFinish & ~pwrite & ~badAccess) ? rdMux : 32'h0000_0000;
    end
  end

  // software settings; only I-field and short burst feed the link
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ctrl_r <= hrc_pkg::CTRL_RESET;
      ifield_r <= hrc_pkg::IFIELD_RESET;
      shBurst_r <= hrc_pkg::SHBURST_RESET;
    end else if (doWrite) begin
      if (selCtrl) ctrl_r <= pwdata[hrc_pkg::CTRL_W-1:0];
      if (selIfield) ifield_r <= pwdata;
      if (selShBurst) shBurst_r <= pwdata[7:0];
    end
  end

  // transmit connection and packet sequencer
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      txState_r <= hrc_pkg::TX_IDLE;
      txRequest <= 1'b0;
      txIfield <= 32'h0000_0000;
      txPacket <= 1'b0;
    end else begin
      unique case (txState_r)
        hrc_pkg::TX_IDLE: begin
          if (lenWrite & ctrl_r[hrc_pkg::CTRL_TX_EN]) begin
            txIfield <= ifield_r;
            txRequest <= 1'b1;
            txState_r <= hrc_pkg::TX_CONNECT;
          end
        end
        hrc_pkg::TX_CONNECT: begin
          if (ackS) begin
            txPacket <= 1'b1;
            txState_r <= hrc_pkg::TX_PACKET;
          end
        end
        hrc_pkg::TX_OPEN: begin
          if (cmdDisc) begin
            txRequest <= 1'b0;
            txState_r <= hrc_pkg::TX_DROP;
          end else if (lenWrite) begin
            txPacket <= 1'b1;
            txState_r <= hrc_pkg::TX_PACKET;
          end
        end
        hrc_pkg::TX_PACKET: begin
          // multi-write holds the packet over writes until ended
          if (packetEnd) begin
            txPacket <= 1'b0;
            if (ctrl_r[hrc_pkg::CTRL_LONG_TERM]) begin
              txState_r <= hrc_pkg::TX_OPEN;
            end else begin
              txRequest <= 1'b0;
              txState_r <= hrc_pkg::TX_DROP;
            end
          end
        end
        hrc_pkg::TX_DROP: begin
          if (!ackS) txState_r <= hrc_pkg::TX_IDLE;
        end
        default: txState_r <= hrc_pkg::TX_IDLE;
      endcase
    end
  end

  // word and burst counting; data words go out exactly as written
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wordsLeft_r <= '0;
      burstLeft_r <= 9'h000;
      txBurst <= 1'b0;
      txWordValid <= 1'b0;
      txData <= 32'h0000_0000;
    end else begin
      txWordValid <= wordSend;
      if (wordSend) txData <= pwdata;
      if (lenLoad) begin
        wordsLeft_r <= lenWords;
      end else if (wordSend) begin
        wordsLeft_r <= wordsLeft_r - 1'b1;
      end else if (packetEnd) begin
        wordsLeft_r <= '0; // early end drops what is left
      end
      // every burst after the first falls back to the standard length
      if (txState_r == hrc_pkg::TX_CONNECT || (txState_r == hrc_pkg::TX_OPEN && lenWrite)) begin
        burstLeft_r <= firstBurst;
      end else if (wordSend) begin
        burstLeft_r <= (burstLeft_r == 9'h001) ? hrc_pkg::STD_BURST_WORDS
          : burstLeft_r - 1'b1;
      end
      if (packetEnd && !wordSend) begin
        txBurst <= 1'b0;
      end else if (wordSend) begin
        txBurst <= 1'b1;
      end else if (burstLeft_r == hrc_pkg::STD_BURST_WORDS || !inPacket) begin
        txBurst <= 1'b0; // gap after a finished burst
      end
    end
  end

  // receive connection: every request accepted while receive accept is set, I-field kept verbatim
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rxConnect <= 1'b0;
      rxIfieldHold_r <= 32'h0000_0000;
    end else begin
      rxConnect <= rxReqS & (ctrl_r[hrc_pkg::CTRL_RX_ACCEPT] | rxConnect);
      if (rxReqS & ~rxConnect & ctrl_r[hrc_pkg::CTRL_RX_ACCEPT]) begin
        rxIfieldHold_r <= rxIfieldS;
      end
    end
  end

  // receive queue; ready leaves room for words still in the synchroniser
  wire rxPush = rxValidS & rxConnect;
  wire rxFirst = rxPacketS & ~rxPacketPrev_r;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rxqWr_r <= '0;
      rxqRd_r <= '0;
      rxqCount_r <= 4'h0;
      rxReady <= 1'b0;
      rxPacketPrev_r <= 1'b0;
      rxOffset_r <= 32'h0000_0000;
    end else begin
      rxPacketPrev_r <= rxPacketS;
      if (rxPush) begin
        rxqData_r[rxqWr_r] <= rxDataS;
        rxqFirst_r[rxqWr_r] <= rxFirst;
        rxqWr_r <= rxqWr_r + 1'b1;
      end
      if (rxPop) begin
        rxqRd_r <= rxqRd_r + 1'b1;
        rxOffset_r <= rxqFirst_r[rxqRd_r] ? 32'(hrc_pkg::BYTES_PER_WORD)
          : rxOffset_r + 32'(hrc_pkg::BYTES_PER_WORD);
      end
      rxqCount_r <= rxqCount_r + {3'h0, rxPush} - {3'h0, rxPop};
      rxReady <= rxConnect & (rxqCount_r < hrc_pkg::RXQ_READY_LIMIT);
    end
  end
endmodule : hrc_raw_access

// ==== logic/hrc_sync.sv ====
`timescale 1ns/10ps
module hrc_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  // two-stage synchroniser; first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : hrc_sync

// ==== test/hrc_raw_access_properties.sv ====
`timescale 1ns/10ps
module hrc_raw_access_properties (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic txRequest,
  input wire logic [31:0] txIfield,
  input wire logic txPacket,
  input wire logic txBurst,
  input wire logic txWordValid,
  input wire logic rxRequest,
  input wire logic rxConnect
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  // bus answer shape: one pulse, inside an access, data only with it
  ready_one_cycle_a: assert property (pready |=> !pready) else $error("pready held");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("lone pslverr");
  ready_in_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
  rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("stale prdata");
  // link words only inside packet, burst and connection
  word_in_packet_a: assert property (txWordValid |-> $past(txPacket)) else $error("word outside packet");
  word_in_burst_a: assert property (txWordValid |-> txBurst) else $error("word outside burst");
  packet_in_conn_a: assert property (txPacket |-> txRequest) else $error("packet without link");
  // ifield latched for the whole connection, host edits must not leak
  ifield_hold_a: assert property (txRequest && $past(txRequest) |-> $stable(txIfield))
    else $error("ifield moved");
  // two sync flops plus one register from the incoming request
  rx_accept_a: assert property (rxConnect |-> $past(rxRequest, 3)) else $error("bad accept");
  cover property ($fell(txPacket));
  cover property (pslverr);
  cover property ($rose(rxConnect));
endmodule : hrc_raw_access_properties

bind hrc_raw_access hrc_raw_access_properties u_props (.sys_clk, .srst, .psel, .penable,
  .prdata, .pready, .pslverr, .txRequest, .txIfield, .txPacket, .txBurst, .txWordValid,
  .rxRequest, .rxConnect);

// ==== test/hrc_raw_access_tb.sv ====
`timescale 1ns/10ps
module hrc_raw_access_tb;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, txIfield, txData, rxIfield, rxData, rd;
  logic pready, pslverr, txRequest, txPacket, txBurst, txWordValid, er;
  logic txConnectAck, txRemoteReady, rxRequest, rxPacket, rxWordValid, rxConnect, rxReady;
  int fail_count = 0;
  int compares = 0;
  int cyc = 0;
  logic [31:0] expq[$];

  always #2 sys_clk = ~sys_clk;

  hrc_raw_access u_hrc_raw_access (.sys_clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .txRequest, .txIfield, .txPacket, .txBurst, .txWordValid,
    .txData, .txConnectAck, .txRemoteReady, .rxRequest, .rxIfield, .rxPacket, .rxWordValid,
    .rxData, .rxConnect, .rxReady);
  hrc_remote_node u_hrc_remote_node (.sys_clk, .txRequest, .txIfield, .txBurst, .txWordValid,
    .txData, .txConnectAck, .txRemoteReady, .rxRequest, .rxIfield, .rxPacket, .rxWordValid,
    .rxData, .rxConnect, .rxReady);

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // request held until pready is sampled, then released
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic idle_wait;
    do apb(1'b0, hrc_pkg::OFF_STATUS, 32'h0); while (rd[2:0] !== 3'h0);
  endtask : idle_wait

  task automatic send(input logic [31:0] len, input logic [31:0] base, input int n);
    apb(1'b1, hrc_pkg::OFF_TXLEN, len);
    for (int i = 0; i < n; i++) begin
      apb(1'b1, hrc_pkg::OFF_TXDATA, base + 32'(i));
      expq.push_back(base + 32'(i));
    end
  endtask : send

  task automatic words;
    chk("word count", 32'(expq.size()), 32'(u_hrc_remote_node.txWords.size()));
    foreach (expq[i]) chk("tx word", expq[i], u_hrc_remote_node.txWords[i]);
    expq.delete();
    u_hrc_remote_node.txWords.delete();
  endtask : words

  task automatic close_out;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : close_out

  // hang guard, a few hundred cycles expected
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  initial begin
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    apb(1'b0, hrc_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", {28'h0, hrc_pkg::CTRL_RESET}, rd);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped err", 32'h1, 32'(er));
    apb(1'b1, hrc_pkg::OFF_STATUS, 32'hFFFF_FFFF);
    chk("ro write err", 32'h1, 32'(er));
    $display("test registers done");
    apb(1'b1, hrc_pkg::OFF_IFIELD, 32'h1234_5678);
    apb(1'b1, hrc_pkg::OFF_SHBURST, 32'h2);
    apb(1'b1, hrc_pkg::OFF_CTRL, 32'h1);
    send(32'h10, 32'hA000_0000, 4);
    idle_wait();
    chk("packet low", 32'h0, 32'(txPacket));
    chk("link closed", 32'h0, 32'(txRequest));
    chk("ifield", 32'h1234_5678, u_hrc_remote_node.ifieldSeen);
    chk("bursts", 32'h2, 32'(u_hrc_remote_node.burstCount));
    words();
    $display("test single done");
    apb(1'b1, hrc_pkg::OFF_IFIELD, 32'hCAFE_0001);
    apb(1'b1, hrc_pkg::OFF_CTRL, 32'h7);
    send(32'h8, 32'hC000_0000, 2);
    send(32'h10, 32'hC100_0000, 2);
    chk("packet held", 32'h1, 32'(txPacket));
    apb(1'b1, hrc_pkg::OFF_IFIELD, 32'hCAFE_0002);
    chk("ifield held", 32'hCAFE_0001, txIfield);
    apb(1'b1, hrc_pkg::OFF_CMD, 32'h1);
    apb(1'b0, hrc_pkg::OFF_STATUS, 32'h0);
    chk("open state", 32'h2, {29'h0, rd[2:0]});
    chk("early end", 32'h0, 32'(txPacket));
    send(32'h8, 32'hC200_0000, 2);
    apb(1'b1, hrc_pkg::OFF_CMD, 32'h1);
    chk("connections", 32'h2, 32'(u_hrc_remote_node.connCount));
    apb(1'b1, hrc_pkg::OFF_CMD, 32'h2);
    idle_wait();
    chk("disconnected", 32'h0, 32'(txRequest));
    chk("ifield 2", 32'hCAFE_0001, u_hrc_remote_node.ifieldSeen);
    words();
    $display("test long term done");
    apb(1'b1, hrc_pkg::OFF_CTRL, 32'h8);
    fork
      begin
        u_hrc_remote_node.send_pkt(32'h5A5A_0003, 32'hB000_0000, 2);
        u_hrc_remote_node.send_pkt(32'h5A5A_0003, 32'hB100_0000, 2);
      end
    join_none
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, hrc_pkg::OFF_RXDATA, 32'h0);
      chk("rx word", (i < 2 ? 32'hB000_0000 : 32'hB100_0000) + 32'(i % 2), rd);
      apb(1'b0, hrc_pkg::OFF_RXOFFSET, 32'h0);
      chk("rx offset", 32'(4 * (i % 2 + 1)), rd);
    end
    apb(1'b0, hrc_pkg::OFF_RXIFIELD, 32'h0);
    chk("rx ifield", 32'h5A5A_0003, rd);
    apb(1'b0, hrc_pkg::OFF_STATUS, 32'h0);
    chk("rx linked", 32'h1, {31'h0, rd[7]});
    chk("rx queue empty", 32'h0, {28'h0, rd[15:12]});
    $display("test receive done");
    close_out();
  end
endmodule : hrc_raw_access_tb

// ==== test/hrc_remote_node.sv ====
`timescale 1ns/10ps
module hrc_remote_node (
  input wire logic sys_clk,
  input wire logic txRequest,
  input wire logic [31:0] txIfield,
  input wire logic txBurst,
  input wire logic txWordValid,
  input wire logic [31:0] txData,
  output logic txConnectAck,
  output logic txRemoteReady,
  output logic rxRequest,
  output logic [31:0] rxIfield,
  output logic rxPacket,
  output logic rxWordValid,
  output logic [31:0] rxData,
  input wire logic rxConnect,
  input wire logic rxReady
);
  int ackCnt = 0;
  int rdyCnt = 0;
  int burstCount = 0;
  int connCount = 0;
  logic lastReq = 1'b0;
  logic lastBurst = 1'b0;
  logic [31:0] ifieldSeen = 32'h0;
  logic [31:0] txWords[$];
  initial begin
    {txConnectAck, rxRequest, rxPacket, rxWordValid} = 4'h0;
    txRemoteReady = 1'b1;
    rxIfield = 32'hFFFF_FFFF;
    rxData = 32'hFFFF_FFFF;
  end
  // ack lags the request on purpose so the sync path is exercised
  always @(posedge sys_clk) begin
    ackCnt <= txRequest ? ackCnt + 1 : 0;
    rdyCnt <= rdyCnt + 1;
    txRemoteReady <= (rdyCnt % 4) != 3; // drops now and then so data words must wait
    txConnectAck <= txRequest && ackCnt >= 5;
    lastReq <= txRequest;
    lastBurst <= txBurst;
    if (txRequest && !lastReq) begin
      connCount++;
      ifieldSeen <= txIfield;
    end
    if (txBurst && !lastBurst) burstCount++;
    if (txWordValid) txWords.push_back(txData);
  end
  // one word per two cycles, only while accepted and room is left
  task automatic send_pkt(input logic [31:0] ifld, input logic [31:0] base, input int n);
    int i;
    rxIfield <= ifld;
    rxRequest <= 1'b1;
    i = 0;
    while (i < n) begin
      @(posedge sys_clk);
      if (rxConnect && rxReady) begin
        rxPacket <= 1'b1;
        rxWordValid <= 1'b1;
        rxData <= base + 32'(i);
        @(posedge sys_clk);
        rxWordValid <= 1'b0;
        rxData <= ~(base + 32'(i));
        i++;
      end
    end
    @(posedge sys_clk);
    rxPacket <= 1'b0;
    @(posedge sys_clk);
  endtask : send_pkt
endmodule : hrc_remote_node
